//--- core/sup_timer.sv
// Function
// [RULE_01] watchdog cleared only by A then 5
// [RULE_02] clear writes ignored while idle
// [RULE_03] timer mode: clear bit0 zeroes counter
// [RULE_04] clear field always reads zero
// [RULE_05] mode codes idle, reserved, watchdog, timer
// [RULE_06] idle code stops timer mode
// [RULE_07] mode writes ignored once watchdog runs
// [RULE_08] software idles timer before watchdog start
// [RULE_09] interval codes select 32768/8192/512/64
// [RULE_10] interval latched only while idle
// [RULE_11] clock division shortens interval when enabled
// [RULE_12] 15-bit hidden counter on slow clock
// [RULE_13] disabled at reset, starts from zero
// [RULE_14] watchdog expiry resets system, no irq
// [RULE_15] timer expiry sets masked irq flag
// [RULE_16] arm on A, disarm on timeout/other
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module sup_timer #(
	parameter bit DIV_SHORTENS = 1'b1
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic resetn_in,
	// register port
	input wire sup_timer_pkg::reg_req_s req_in,
	output logic [7:0] rdata_out,
	// slow clock from pin
	input wire logic slow_clk_in,
	// outputs
	output logic irq_out,
	output logic sys_reset_out
);
	import sup_timer_pkg::*;

	timer_state_s st_r;
	timer_state_s st_nxt;
	logic tick;
	logic ctrl_wr;
	logic [3:0] clr_w;
	logic [1:0] mode_w;
	logic [14:0] tc;
	logic [15:0] span;
	logic [15:0] span_div;
	logic [14:0] tc_eff;
	logic expire;

	////////////////////////////////////////////////////////////
	// decode
	always_comb begin
		ctrl_wr = req_in.wr && (req_in.addr == CTRL_OFFSET);
		clr_w = req_in.wdata[CLR_LSB +: 4];
		mode_w = req_in.wdata[MODE_LSB +: 2];
		tick = st_r.tick_sync[1] && !st_r.tick_prev;
		case (st_r.interval) // [RULE_09]
			2'h0: tc = TC_32768;
			2'h1: tc = TC_8192;
			2'h2: tc = TC_512;
			default: tc = TC_64;
		endcase
		// divided system clock shortens the interval by 2^div_sel
		span = {1'b0, tc} + 16'h0001;
		if (DIV_SHORTENS) // [RULE_11]
			span_div = span >> st_r.div_sel;
		else
			span_div = span;
		if (span_div == 16'h0000)
			tc_eff = 15'h0000;
		else
			tc_eff = 15'(span_div - 16'h0001);
		expire = st_r.count >= tc_eff;
	end

	////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick_sync = {st_r.tick_sync[0], slow_clk_in};
		st_nxt.tick_prev = st_r.tick_sync[1];
		st_nxt.sys_reset = 1'b0;
		if (tick) begin
			st_nxt.arm_tick_seen = st_r.armed;
			if (st_r.armed && st_r.arm_tick_seen)
				st_nxt.armed = 1'b0; // [RULE_16]
		end
		if (tick && st_r.state != ST_IDLE) begin
			st_nxt.count = st_r.count + 15'h0001; // [RULE_12]
			if (expire) begin
				st_nxt.count = COUNT_RESET;
				if (st_r.state == ST_WDOG)
					st_nxt.sys_reset = 1'b1; // [RULE_14]
				else
					st_nxt.irq_flag = 1'b1; // [RULE_15]
			end
		end
		if (ctrl_wr) begin
			case (st_r.state)
				ST_IDLE: begin
					st_nxt.interval = req_in.wdata[INT_LSB +: 2]; // [RULE_10]
					st_nxt.count = COUNT_RESET; // [RULE_13]
					st_nxt.armed = 1'b0; // [RULE_02]
					if (mode_w == MODE_WDOG)
						st_nxt.state = ST_WDOG; // [RULE_05]
					else if (mode_w == MODE_TIMER)
						st_nxt.state = ST_TIMER;
				end
				ST_TIMER: begin
					if (clr_w[0])
						st_nxt.count = COUNT_RESET; // [RULE_03]
					if (mode_w == MODE_IDLE) begin
						st_nxt.state = ST_IDLE; // [RULE_06]
						st_nxt.count = COUNT_RESET;
					end
				end
				ST_WDOG: begin
					// mode and interval bits ignored here [RULE_07]
					if (st_r.armed && clr_w == KEY_FIRE) begin
						st_nxt.count = COUNT_RESET; // [RULE_01]
						st_nxt.armed = 1'b0;
					end else if (clr_w == KEY_ARM) begin
						st_nxt.armed = 1'b1; // [RULE_16]
						st_nxt.arm_tick_seen = 1'b0;
					end else begin
						st_nxt.armed = 1'b0; // [RULE_16]
					end
				end
				default: st_nxt.state = ST_IDLE;
			endcase
		end
		if (req_in.wr && req_in.addr == IRQ_STATUS_OFFSET && req_in.wdata[0])
			st_nxt.irq_flag = st_nxt.irq_flag && tick && expire && st_r.state == ST_TIMER;
		if (req_in.wr && req_in.addr == IRQ_MASK_OFFSET)
			st_nxt.irq_mask = req_in.wdata[0];
		if (req_in.wr && req_in.addr == CLK_DIV_OFFSET)
			st_nxt.div_sel = req_in.wdata[2:0];
		st_nxt.rdata = 8'h00;
		if (req_in.rd) begin
			case (req_in.addr)
				CTRL_OFFSET: begin
					// clear field reads zero [RULE_04]
					st_nxt.rdata[MODE_LSB +: 2] = (st_r.state == ST_WDOG) ? MODE_WDOG :
						(st_r.state == ST_TIMER) ? MODE_TIMER : MODE_IDLE;
					st_nxt.rdata[INT_LSB +: 2] = st_r.interval;
				end
				IRQ_STATUS_OFFSET: st_nxt.rdata = {7'h00, st_r.irq_flag};
				IRQ_MASK_OFFSET: st_nxt.rdata = {7'h00, st_r.irq_mask};
				CLK_DIV_OFFSET: st_nxt.rdata = {5'h00, st_r.div_sel};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_out = st_r.rdata;
	assign irq_out = st_r.irq_flag && st_r.irq_mask;
	assign sys_reset_out = st_r.sys_reset;

	////////////////////////////////////////////////////////////
	// assertions
	property p_wdog_no_irq;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG && !st_r.irq_flag |=> !st_r.irq_flag;
	endproperty
	a_wdog_no_irq: assert property (p_wdog_no_irq) else $error("irq set in watchdog"); // [RULE_14]

	property p_timer_no_reset;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state != ST_WDOG |=> !sys_reset_out;
	endproperty
	a_timer_no_reset: assert property (p_timer_no_reset) else $error("reset outside watchdog"); // [RULE_15]

	property p_wdog_sticky;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG |=> st_r.state == ST_WDOG;
	endproperty
	a_wdog_sticky: assert property (p_wdog_sticky) else $error("watchdog left"); // [RULE_07]

	property p_clr_reads_zero;
		@(posedge core_clk_in) disable iff (!resetn_in)
		req_in.rd && req_in.addr == CTRL_OFFSET |=> rdata_out[7:4] == 4'h0;
	endproperty
	a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear field nonzero"); // [RULE_04]

	property p_idle_stop;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_TIMER && ctrl_wr && mode_w == MODE_IDLE |=> st_r.state == ST_IDLE && st_r.count == 15'h0000;
	endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("timer not stopped"); // [RULE_06]

	property p_idle_frozen;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_IDLE && !ctrl_wr |=> st_r.count == 15'h0000;
	endproperty
	a_idle_frozen: assert property (p_idle_frozen) else $error("idle counter moved"); // [RULE_13]

	property p_interval_hold;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state != ST_IDLE |=> $stable(st_r.interval);
	endproperty
	a_interval_hold: assert property (p_interval_hold) else $error("interval changed"); // [RULE_10]

	property p_timer_clear;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_TIMER && ctrl_wr && clr_w[0] |=> st_r.count == 15'h0000;
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer clear failed"); // [RULE_03]

	property p_key_clear;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG && st_r.armed && ctrl_wr && clr_w == KEY_FIRE |=> st_r.count == 15'h0000 && !st_r.armed;
	endproperty
	a_key_clear: assert property (p_key_clear) else $error("key clear failed"); // [RULE_01]

	property p_unarmed_no_clear;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG && !st_r.armed && ctrl_wr && clr_w == KEY_FIRE && !tick |=> $stable(st_r.count);
	endproperty
	a_unarmed_no_clear: assert property (p_unarmed_no_clear) else $error("clear without key"); // [RULE_01]

	property p_wdog_expire;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG && tick && expire |=> sys_reset_out;
	endproperty
	a_wdog_expire: assert property (p_wdog_expire) else $error("no reset on expiry"); // [RULE_14]

	property p_reset_pulse;
		@(posedge core_clk_in) disable iff (!resetn_in)
		sys_reset_out |=> !sys_reset_out;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long"); // [RULE_14]

	property p_timer_expire;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_TIMER && tick && expire |=> st_r.irq_flag;
	endproperty
	a_timer_expire: assert property (p_timer_expire) else $error("no flag on expiry"); // [RULE_15]

	property p_irq_clear;
		@(posedge core_clk_in) disable iff (!resetn_in)
		req_in.wr && req_in.addr == IRQ_STATUS_OFFSET && req_in.wdata[0] && !(tick && expire && st_r.state == ST_TIMER)
			|=> !st_r.irq_flag;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("flag not cleared"); // [RULE_15]

	property p_idle_stays;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_IDLE && ctrl_wr && (mode_w == MODE_RSVD || mode_w == MODE_IDLE) |=> st_r.state == ST_IDLE;
	endproperty
	a_idle_stays: assert property (p_idle_stays) else $error("idle left"); // [RULE_02]

	property p_start_zero;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_IDLE && ctrl_wr && (mode_w == MODE_WDOG || mode_w == MODE_TIMER)
			|=> st_r.state != ST_IDLE && st_r.count == 15'h0000;
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("start not from zero"); // [RULE_13]

	property p_timer_no_wdog;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_TIMER && ctrl_wr && mode_w == MODE_WDOG |=> st_r.state == ST_TIMER;
	endproperty
	a_timer_no_wdog: assert property (p_timer_no_wdog) else $error("timer jumped to watchdog"); // [RULE_05]

	property p_count_step;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state != ST_IDLE && tick && !expire && !ctrl_wr |=> st_r.count == $past(st_r.count) + 15'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("count step wrong"); // [RULE_12]

	property p_count_hold;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state != ST_IDLE && !tick && !ctrl_wr |=> $stable(st_r.count);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without tick"); // [RULE_12]

	property p_arm_key;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.state == ST_WDOG && ctrl_wr && clr_w == KEY_ARM |=> st_r.armed;
	endproperty
	a_arm_key: assert property (p_arm_key) else $error("key not armed"); // [RULE_16]

	property p_disarm_timeout;
		@(posedge core_clk_in) disable iff (!resetn_in)
		st_r.armed && st_r.arm_tick_seen && tick && !ctrl_wr |=> !st_r.armed;
	endproperty
	a_disarm_timeout: assert property (p_disarm_timeout) else $error("arm window kept"); // [RULE_16]

	property p_rdata_idle;
		@(posedge core_clk_in) disable iff (!resetn_in)
		!req_in.rd |=> rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read"); // [RULE_04]

	property p_mode_readback;
		@(posedge core_clk_in) disable iff (!resetn_in)
		req_in.rd && req_in.addr == CTRL_OFFSET |=> rdata_out[MODE_LSB +: 2] != MODE_RSVD;
	endproperty
	a_mode_readback: assert property (p_mode_readback) else $error("reserved mode read"); // [RULE_05]

	c_wdog_start: cover property (@(posedge core_clk_in) st_r.state == ST_IDLE ##1 st_r.state == ST_WDOG);
	c_timer_irq: cover property (@(posedge core_clk_in) st_r.state == ST_TIMER && irq_out);
	c_wdog_reset: cover property (@(posedge core_clk_in) sys_reset_out);
	c_key_seq: cover property (@(posedge core_clk_in) st_r.armed ##1 !st_r.armed && st_r.count == 15'h0000);
	c_div_expire: cover property (@(posedge core_clk_in) st_r.div_sel != 3'h0 && tick && expire && st_r.state == ST_TIMER);
endmodule

//--- core/sup_timer_pkg.sv
package sup_timer_pkg;
	// register map
	localparam logic [7:0] CTRL_OFFSET = 8'hC9;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hCA;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'hCB;
	localparam logic [7:0] CLK_DIV_OFFSET = 8'hCC;
	// control field positions
	localparam int CLR_LSB = 4;
	localparam int MODE_LSB = 2;
	localparam int INT_LSB = 0;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [14:0] COUNT_RESET = 15'h0000;
	// clear keys
	localparam logic [3:0] KEY_ARM = 4'hA;
	localparam logic [3:0] KEY_FIRE = 4'h5;
	// mode codes
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_RSVD = 2'h1;
	localparam logic [1:0] MODE_WDOG = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	// interval terminal counts (periods minus one)
	localparam logic [14:0] TC_32768 = 15'h7FFF;
	localparam logic [14:0] TC_8192 = 15'h1FFF;
	localparam logic [14:0] TC_512 = 15'h01FF;
	localparam logic [14:0] TC_64 = 15'h003F;
	// low-frequency tick timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_SYNC_STAGES = 2;

	typedef enum logic [1:0] {ST_IDLE, ST_WDOG, ST_TIMER} run_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		run_state_e state;
		logic [1:0] interval;
		logic [14:0] count;
		logic [2:0] div_sel;
		logic armed;
		logic arm_tick_seen;
		logic [1:0] tick_sync;
		logic tick_prev;
		logic irq_flag;
		logic irq_mask;
		logic sys_reset;
		logic [7:0] rdata;
	} timer_state_s;
endpackage

//--- testbench/sup_timer_bench.sv
`timescale 1ns/10ps
module sup_timer_bench;
	import sup_timer_pkg::*;
	logic core_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic slow_clk_in = 1'b0;
	reg_req_s req = '0;
	logic [7:0] rdata_out;
	logic irq_out;
	logic sys_reset_out;
	int err_count = 0;
	int comparisons = 0;
	int rst_pulses = 0;
	int irq_hi = 0;
	logic [7:0] rd_val;

	sup_timer #(.DIV_SHORTENS(1'b1)) i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .req_in(req),
		.rdata_out(rdata_out), .slow_clk_in(slow_clk_in), .irq_out(irq_out), .sys_reset_out(sys_reset_out));

	always #5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		if (sys_reset_out === 1'b1) rst_pulses++;
		if (irq_out === 1'b1) irq_hi++;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_in);
		req <= '0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_in);
		req <= '0;
		#1 d = rdata_out;
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge core_clk_in);
			slow_clk_in <= 1'b1;
			repeat (4) @(posedge core_clk_in);
			slow_clk_in <= 1'b0;
			repeat (3) @(posedge core_clk_in);
		end
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, CTRL_RESET);
		reg_rd(8'h10, rd_val);
		chk(rd_val, 8'h00);
		ticks(70);
		chk({7'h00, irq_out | sys_reset_out}, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_timer();
		reg_wr(IRQ_MASK_OFFSET, 8'h01);
		reg_wr(CTRL_OFFSET, 8'hFF);
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, 8'h0F);
		ticks(63);
		chk({7'h00, irq_out}, 8'h00);
		ticks(1);
		chk({7'h00, irq_out}, 8'h01);
		reg_wr(IRQ_STATUS_OFFSET, 8'h01);
		#1 chk({7'h00, irq_out}, 8'h00);
		ticks(40);
		reg_wr(CTRL_OFFSET, 8'h1D);
		ticks(63);
		chk({7'h00, irq_out}, 8'h00);
		ticks(1);
		chk({7'h00, irq_out}, 8'h01);
		chk(rst_pulses[7:0], 8'h00);
		reg_wr(IRQ_STATUS_OFFSET, 8'h01);
		$display("test timer done");
	endtask
	task automatic t_idle();
		reg_wr(CTRL_OFFSET, 8'h00);
		reg_wr(CTRL_OFFSET, 8'hA0);
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, 8'h00);
		reg_wr(CTRL_OFFSET, 8'h07);
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, 8'h03);
		irq_hi = 0;
		ticks(70);
		chk(irq_hi[7:0], 8'h00);
		$display("test idle done");
	endtask
	task automatic t_wdog();
		irq_hi = 0;
		reg_wr(CTRL_OFFSET, 8'h0B);
		ticks(30);
		reg_wr(CTRL_OFFSET, 8'hA0);
		reg_wr(CTRL_OFFSET, 8'h50);
		ticks(63);
		chk(rst_pulses[7:0], 8'h00);
		reg_wr(CTRL_OFFSET, 8'h0C);
		reg_wr(CTRL_OFFSET, 8'h00);
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, 8'h0B);
		reg_wr(CTRL_OFFSET, 8'hA0);
		reg_wr(CTRL_OFFSET, 8'h50);
		ticks(40);
		reg_wr(CTRL_OFFSET, 8'hA0);
		ticks(2);
		reg_wr(CTRL_OFFSET, 8'h50);
		ticks(21);
		chk(rst_pulses[7:0], 8'h00);
		ticks(1);
		chk(rst_pulses[7:0], 8'h01);
		chk(irq_hi[7:0], 8'h00);
		$display("test watchdog done");
	endtask
	task automatic t_div();
		@(posedge core_clk_in);
		resetn_in <= 1'b0;
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		reg_rd(CTRL_OFFSET, rd_val);
		chk(rd_val, CTRL_RESET);
		reg_wr(CLK_DIV_OFFSET, 8'h03);
		reg_wr(CTRL_OFFSET, 8'h0F);
		ticks(7);
		reg_rd(IRQ_STATUS_OFFSET, rd_val);
		chk(rd_val, 8'h00);
		ticks(1);
		reg_rd(IRQ_STATUS_OFFSET, rd_val);
		chk(rd_val, 8'h01);
		chk({7'h00, irq_out}, 8'h00);
		reg_wr(IRQ_MASK_OFFSET, 8'h01);
		#1 chk({7'h00, irq_out}, 8'h01);
		$display("test division done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge core_clk_in);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		t_reset();
		t_timer();
		t_idle();
		t_wdog();
		t_div();
		wrap_up();
	end
endmodule
